// >>> uart_ier_pkg.sv
// Constants and carrier types for the interrupt enable and ready block.
// Assumes a host bus with a 3-bit register address and 8-bit data.
package uart_enables_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [2:0] ADDR_ENABLES = 3'h1;
  localparam logic [2:0] ADDR_QCR = 3'h2;
  localparam logic [2:0] ADDR_ICR = 3'h2;
  localparam logic [2:0] ADDR_LCR = 3'h5;
  localparam logic [7:0] ENABLES_RESET = 8'h00;
  localparam logic [7:0] QCR_RESET = 8'h00;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int unsigned IE_RX_DATA = 0;
  localparam int unsigned IE_TX_EMPTY = 1;
  localparam int unsigned IE_LINE = 2;
  localparam int unsigned IE_MODEM = 3;
  localparam int unsigned IE_SLEEP = 4;
  localparam int unsigned IE_XOFF = 5;
  localparam int unsigned IE_RTS = 6;
  localparam int unsigned IE_CTS = 7;
  localparam int unsigned QC_ENABLE = 0;
  localparam int unsigned QC_RX_RESET = 1;
  localparam int unsigned QC_TX_RESET = 2;
  localparam int unsigned QC_DMA_MODE = 3;
  localparam int unsigned QC_TRIG_LSB = 6;

  // ----------------------------------------------------------------
  // Queue depth and trigger levels
  // ----------------------------------------------------------------
  localparam logic [4:0] FIFO_DEPTH = 5'h10;
  localparam logic [4:0] TRIG_LVL0 = 5'h01;
  localparam logic [4:0] TRIG_LVL1 = 5'h04;
  localparam logic [4:0] TRIG_LVL2 = 5'h08;
  localparam logic [4:0] TRIG_LVL3 = 5'h0E;

  // ----------------------------------------------------------------
  // Interrupt cause codes (low nibble of the cause register)
  // ----------------------------------------------------------------
  localparam logic [3:0] CAUSE_NONE = 4'h1;
  localparam logic [3:0] CAUSE_LINE = 4'h6;
  localparam logic [3:0] CAUSE_RX = 4'h4;
  localparam logic [3:0] CAUSE_TX = 4'h2;
  localparam logic [3:0] CAUSE_MODEM = 4'h0;
  localparam logic [3:0] CAUSE_XOFF = 4'h0;

  typedef enum logic {DMA_MODE0, DMA_MODE1} dma_mode_e;

  // Status arriving from the data path.
  typedef struct packed {
    logic [4:0] rx_fill;
    logic [4:0] tx_fill;
    logic tx_shift_empty;
    logic [3:0] rx_errors;
    logic fifo_data_error;
    logic rx_char_loaded;
    logic xoff_received;
    logic modem_change;
    logic cts_n;
    logic rts_n;
  } datapath_status_s;

  // Control delivered to the data path.
  typedef struct packed {
    logic fifo_enable;
    logic rx_fifo_reset;
    logic tx_fifo_reset;
    logic sleep_allowed;
  } datapath_ctrl_s;

endpackage : uart_enables_pkg

// >>> uart_ier_ready.sv
// Interrupt source enables, receive trigger interrupt, polled status and DMA ready pins.
// Assumes a synchronous register bus with single-cycle read and write strobes.
//
// Functional notes
// - CTS rising edge interrupts when bit 7 set.
// - RTS rising edge interrupts when bit 6 set.
// - Bit 5 gates the Xoff received interrupt.
// - Bit 4 permits sleep mode.
// - Bit 3 gates the modem status interrupt.
// - Bit 2 interrupts on each received character.
// - Bit 1 interrupts while transmit holding empty.
// - Bit 0 raises receive interrupt at trigger.
// - All enable bits reset to zero.
// - Cause register shows receive data at trigger.
// - Data ready set on load, cleared when empty.
// - FIFOs on, bits 0-3 clear: polled mode.
// - Polled line status bits report errors and emptiness.
// - DMA mode 0 ready pins follow single slots.
// - DMA mode 1 transmit interrupt on free location.
// - DMA mode 1 receive interrupt at trigger level.
// - DMA mode 1 receive ready low above trigger.
// - Trigger codes select 1, 4, 8, 14 bytes.
// - Queue control writes need enable bit set.
`timescale 1ns/1ps
`default_nettype none
module uart_enables_ready (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [7:0] reg_rdata,
  input wire uart_enables_pkg::datapath_status_s dp_status,
  output uart_enables_pkg::datapath_ctrl_s dp_ctrl,
  output logic polled_mode,
  output logic transmit_dma_request_n,
  output logic receive_dma_request_n,
  output logic irq
);
  import uart_enables_pkg::*;

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic rst_meta_q;
  logic rst_sync_q;
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [7:0] interrupt_source_enables;
  logic [7:0] queue_control_register;
  logic rx_reset_q;
  logic tx_reset_q;
  logic wr_enables;
  logic wr_qcr;

  assign wr_enables = reg_write && (reg_addr == ADDR_ENABLES);
  assign wr_qcr = reg_write && (reg_addr == ADDR_QCR);

  always_ff @(posedge clk_sys or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      interrupt_source_enables <= ENABLES_RESET;
    end else if (wr_enables) begin
      interrupt_source_enables <= reg_wdata;
    end
  end

  // Writes with the enable bit clear still turn the queues off, but leave the
  // other control bits untouched.
  always_ff @(posedge clk_sys or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      queue_control_register <= QCR_RESET;
    end else if (wr_qcr) begin
      if (reg_wdata[QC_ENABLE]) begin
        queue_control_register <= {reg_wdata[7:6], 2'b00, reg_wdata[3], 3'b001};
      end else begin
        queue_control_register[QC_ENABLE] <= 1'b0;
      end
    end
  end

  // Queue resets are self-clearing one-cycle pulses.
  always_ff @(posedge clk_sys or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      rx_reset_q <= 1'b0;
      tx_reset_q <= 1'b0;
    end else begin
      rx_reset_q <= wr_qcr && reg_wdata[QC_ENABLE] && reg_wdata[QC_RX_RESET];
      tx_reset_q <= wr_qcr && reg_wdata[QC_ENABLE] && reg_wdata[QC_TX_RESET];
    end
  end

  logic fifo_on;
  dma_mode_e dma_mode;
  logic [4:0] trigger_level;

  assign fifo_on = queue_control_register[QC_ENABLE];
  assign dma_mode = (fifo_on && queue_control_register[QC_DMA_MODE]) ? DMA_MODE1 : DMA_MODE0;

  always_comb begin
    unique case (queue_control_register[QC_TRIG_LSB +: 2])
      2'b00: trigger_level = TRIG_LVL0;
      2'b01: trigger_level = TRIG_LVL1;
      2'b10: trigger_level = TRIG_LVL2;
      2'b11: trigger_level = TRIG_LVL3;
    endcase
  end

  assign dp_ctrl = '{fifo_enable: fifo_on, rx_fifo_reset: rx_reset_q,
                     tx_fifo_reset: tx_reset_q,
                     sleep_allowed: interrupt_source_enables[IE_SLEEP]};

  // ----------------------------------------------------------------
  // Receive and transmit levels
  // ----------------------------------------------------------------
  logic rx_any;
  logic rx_at_trigger;
  logic rx_above_trigger;
  logic tx_has_room;
  logic tx_empty;

  assign rx_any = dp_status.rx_fill != 5'h00;
  // Without queues the holding register acts as a one-deep queue with trigger one.
  assign rx_at_trigger = fifo_on ? (dp_status.rx_fill >= trigger_level) : rx_any;
  assign rx_above_trigger = dp_status.rx_fill > trigger_level;
  assign tx_has_room = fifo_on ? (dp_status.tx_fill < FIFO_DEPTH) : (dp_status.tx_fill == 5'h00);
  assign tx_empty = dp_status.tx_fill == 5'h00;

  // ----------------------------------------------------------------
  // Sticky edge events
  // ----------------------------------------------------------------
  logic cts_n_q;
  logic rts_n_q;
  logic cts_rise;
  logic rts_rise;
  logic cts_evt_q;
  logic rts_evt_q;
  logic xoff_evt_q;
  logic line_evt_q;
  logic rd_cause;

  assign rd_cause = reg_read && (reg_addr == ADDR_ICR);
  assign cts_rise = dp_status.cts_n && !cts_n_q;
  assign rts_rise = dp_status.rts_n && !rts_n_q;

  always_ff @(posedge clk_sys or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      cts_n_q <= 1'b1;
      rts_n_q <= 1'b1;
    end else begin
      cts_n_q <= dp_status.cts_n;
      rts_n_q <= dp_status.rts_n;
    end
  end

  // Events are cleared by reading the cause register; a new event in the
  // same cycle wins so that no edge is lost.
  always_ff @(posedge clk_sys or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      cts_evt_q <= 1'b0;
      rts_evt_q <= 1'b0;
      xoff_evt_q <= 1'b0;
    end else begin
      cts_evt_q <= cts_rise || (cts_evt_q && !rd_cause);
      rts_evt_q <= rts_rise || (rts_evt_q && !rd_cause);
      xoff_evt_q <= dp_status.xoff_received || (xoff_evt_q && !rd_cause);
    end
  end

  // Line interrupt is cleared by reading the line condition register.
  always_ff @(posedge clk_sys or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      line_evt_q <= 1'b0;
    end else begin
      line_evt_q <= dp_status.rx_char_loaded ||
                    (line_evt_q && !(reg_read && reg_addr == ADDR_LCR));
    end
  end

  // ----------------------------------------------------------------
  // Pending sources
  // ----------------------------------------------------------------
  logic pend_line;
  logic pend_rx;
  logic pend_tx;
  logic pend_modem;
  logic pend_xoff;
  logic pend_flow;

  assign pend_line = interrupt_source_enables[IE_LINE] && line_evt_q;
  assign pend_rx = interrupt_source_enables[IE_RX_DATA] && rx_at_trigger;
  assign pend_tx = interrupt_source_enables[IE_TX_EMPTY] &&
                   ((dma_mode == DMA_MODE1) ? tx_has_room : tx_empty);
  assign pend_modem = interrupt_source_enables[IE_MODEM] && dp_status.modem_change;
  assign pend_xoff = interrupt_source_enables[IE_XOFF] && xoff_evt_q;
  assign pend_flow = (interrupt_source_enables[IE_CTS] && cts_evt_q) ||
                     (interrupt_source_enables[IE_RTS] && rts_evt_q);

  // Sleep enable is not an interrupt source and never raises the line.
  assign irq = pend_line || pend_rx || pend_tx || pend_modem || pend_xoff || pend_flow;

  assign polled_mode = fifo_on && (interrupt_source_enables[3:0] == 4'h0);

  // ----------------------------------------------------------------
  // Cause and line condition registers
  // ----------------------------------------------------------------
  logic [3:0] cause_code;
  logic [7:0] interrupt_cause_register;
  logic [7:0] line_condition_register;

  always_comb begin
    if (pend_line) begin
      cause_code = CAUSE_LINE;
    end else if (pend_rx) begin
      cause_code = CAUSE_RX;
    end else if (pend_tx) begin
      cause_code = CAUSE_TX;
    end else if (pend_modem || pend_xoff || pend_flow) begin
      cause_code = CAUSE_MODEM;
    end else begin
      cause_code = CAUSE_NONE;
    end
  end

  assign interrupt_cause_register = {{2{fifo_on}}, 2'b00, cause_code};

  assign line_condition_register = {
    dp_status.fifo_data_error,
    tx_empty && dp_status.tx_shift_empty,
    tx_empty,
    dp_status.rx_errors,
    rx_any
  };

  always_ff @(posedge clk_sys or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      reg_rdata <= 8'h00;
    end else if (reg_read) begin
      unique case (reg_addr)
        ADDR_ENABLES: reg_rdata <= interrupt_source_enables;
        ADDR_ICR: reg_rdata <= interrupt_cause_register;
        ADDR_LCR: reg_rdata <= line_condition_register;
        default: reg_rdata <= 8'h00;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // DMA ready pins
  // ----------------------------------------------------------------
  logic rx_ready_hold_q;

  // In mode 1 the receive request latches at the trigger and holds until the
  // queue drains, which covers the span above the trigger level.
  always_ff @(posedge clk_sys or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      rx_ready_hold_q <= 1'b0;
    end else if (!rx_any) begin
      rx_ready_hold_q <= 1'b0;
    end else if (rx_at_trigger) begin
      rx_ready_hold_q <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      transmit_dma_request_n <= 1'b1;
      receive_dma_request_n <= 1'b1;
    end else if (dma_mode == DMA_MODE1) begin
      transmit_dma_request_n <= !tx_has_room;
      receive_dma_request_n <=
        !(rx_any && (rx_ready_hold_q || rx_above_trigger || rx_at_trigger));
    end else begin
      transmit_dma_request_n <= !tx_empty;
      receive_dma_request_n <= !rx_any;
    end
  end

endmodule : uart_enables_ready
`default_nettype wire

// >>> uart_ier_properties.sv
// Port-level assertions for the interrupt enable and ready block.
// Assumes uart_enables_pkg; bound onto every uart_enables_ready instance.
`timescale 1ns/1ps
`default_nettype none
module uart_enables_properties (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [7:0] reg_rdata,
  input wire uart_enables_pkg::datapath_status_s dp_status,
  input wire uart_enables_pkg::datapath_ctrl_s dp_ctrl,
  input wire logic polled_mode,
  input wire logic transmit_dma_request_n,
  input wire logic receive_dma_request_n,
  input wire logic irq
);
  import uart_enables_pkg::*;
  // ----------------------------------------------------------------
  // Shadow state
  // ----------------------------------------------------------------
  // The block's own reset lags two edges, so live checks start after three.
  logic [2:0] live_q;
  logic [7:0] enables_q;
  logic enables_wr;
  assign enables_wr = live_q[2] && reg_write && reg_addr == ADDR_ENABLES;
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      live_q <= 3'h0;
    end else begin
      live_q <= {live_q[1:0], 1'b1};
    end
  end
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      enables_q <= 8'h00;
    end else if (enables_wr) begin
      enables_q <= reg_wdata;
    end
  end
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking main_cb @(posedge clk_sys);
  endclocking
  default disable iff (!reset_n);
  reset_quiet_a: assert property (
    !live_q[1] |-> !irq && transmit_dma_request_n && receive_dma_request_n && dp_ctrl == '0)
    else $error("outputs active in reset");
  sleep_gate_a: assert property (
    enables_wr |=> dp_ctrl.sleep_allowed == $past(reg_wdata[IE_SLEEP]))
    else $error("sleep wrong");
  polled_exit_a: assert property (
    enables_wr && reg_wdata[3:0] != 4'h0 |=> !polled_mode)
    else $error("polled with enables");
  queue_enable_a: assert property (
    live_q[2] && reg_write && reg_addr == ADDR_QCR
    |=> dp_ctrl.fifo_enable == $past(reg_wdata[QC_ENABLE])) else $error("queue enable wrong");
  tx_room_a: assert property (
    live_q[2] && dp_status.tx_fill == 5'h00 |=> !transmit_dma_request_n) else $error("tx pin");
  rx_empty_a: assert property (
    live_q[2] && dp_status.rx_fill == 5'h00 |=> receive_dma_request_n) else $error("rx pin");
  tx_irq_a: assert property (
    live_q[2] && enables_q[IE_TX_EMPTY] && dp_status.tx_fill == 5'h00 |-> irq)
    else $error("no tx irq");
  rx_trig_a: assert property (
    live_q[2] && enables_q[IE_RX_DATA] && dp_status.rx_fill >= 5'h0E |-> ##[0:1] irq)
    else $error("no rx irq");
  all_masked_a: assert property (
    live_q[2] && enables_q[7:5] == 3'h0 && enables_q[3:0] == 4'h0 |-> !irq)
    else $error("masked irq");
  cts_event_a: assert property (
    live_q[2] && enables_q[IE_CTS] && $rose(dp_status.cts_n) |-> ##[1:2] irq)
    else $error("no cts irq");
  cts_seen_c: cover property (enables_q[IE_CTS] && irq);
  rx_block_c: cover property (!receive_dma_request_n && dp_status.rx_fill == FIFO_DEPTH);
  polled_c: cover property (polled_mode);
endmodule : uart_enables_properties
bind uart_enables_ready uart_enables_properties uart_enables_properties_inst (.*);
`default_nettype wire

// >>> fifo_fill_model.sv
// Far-side model: receive and transmit queue fill counters seen by the block.
// Assumes push and pop strobes from the bench and the reset pulses of dp_ctrl.
`timescale 1ns/1ps
`default_nettype none
module fifo_fill_model (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic [3:0] strobe,
  input wire uart_enables_pkg::datapath_ctrl_s dp_ctrl,
  output logic [4:0] rx_fill,
  output logic [4:0] tx_fill,
  output logic rx_char_loaded
);
  import uart_enables_pkg::*;
  // With the queues off only the holding register remains, so depth drops to one.
  logic [4:0] depth;
  logic rx_in;
  logic tx_in;
  assign depth = dp_ctrl.fifo_enable ? FIFO_DEPTH : 5'h01;
  assign rx_in = strobe[0] && rx_fill < depth;
  assign tx_in = strobe[2] && tx_fill < depth;
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rx_fill <= 5'h00;
    end else if (dp_ctrl.rx_fifo_reset) begin
      rx_fill <= 5'h00;
    end else begin
      rx_fill <= rx_fill + 5'(rx_in) - 5'(strobe[1] && rx_fill != 5'h00);
    end
  end
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      tx_fill <= 5'h00;
    end else if (dp_ctrl.tx_fifo_reset) begin
      tx_fill <= 5'h00;
    end else begin
      tx_fill <= tx_fill + 5'(tx_in) - 5'(strobe[3] && tx_fill != 5'h00);
    end
  end
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rx_char_loaded <= 1'b0;
    end else begin
      rx_char_loaded <= rx_in;
    end
  end
endmodule : fifo_fill_model
`default_nettype wire

// >>> testbench.sv
// Self-checking bench of the interrupt enable and ready block.
// Assumes the package, checker and fill model are compiled before it.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import uart_enables_pkg::*;
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic [2:0] reg_addr = 3'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic rd_seen = 1'b0;
  logic shift_e = 1'b1;
  logic fde = 1'b0;
  logic [3:0] errs = 4'h0;
  logic [3:0] fs = 4'h0;
  logic [4:0] ev = 5'h00;
  logic [31:0] seed = 32'h0000_0028;
  logic [7:0] reg_rdata;
  logic polled_mode, tx_n, rx_n, irq, ld;
  logic [4:0] rxf, txf;
  logic [15:0] ent;
  logic [15:0] expq[$];
  logic [4:0] lv[4] = '{5'h01, 5'h04, 5'h08, 5'h0E};
  logic [7:0] eb[5] = '{8'h80, 8'h40, 8'h20, 8'h08, 8'h04};
  logic [4:0] ec[5] = '{5'h10, 5'h08, 5'h04, 5'h02, 5'h00};
  int errors = 0;
  int n_checks = 0;
  datapath_status_s dp_status;
  datapath_ctrl_s dp_ctrl;
  assign dp_status = {rxf, txf, shift_e, errs, fde, ld, ev[2], ev[1], ev[4], ev[3]};
  uart_enables_ready uart_enables_ready_inst (.clk_sys, .reset_n, .reg_addr, .reg_wdata,
    .reg_write, .reg_read, .reg_rdata, .dp_status, .dp_ctrl, .polled_mode,
    .transmit_dma_request_n(tx_n), .receive_dma_request_n(rx_n), .irq);
  fifo_fill_model fifo_fill_model_inst (.clk_sys, .reset_n, .strobe(fs), .dp_ctrl,
    .rx_fill(rxf), .tx_fill(txf), .rx_char_loaded(ld));
  initial begin
    forever #20 clk_sys = ~clk_sys;
  end
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic step(input int n);
    repeat (n) @(negedge clk_sys);
  endtask : step
  task automatic chk(input logic [7:0] e, input logic [7:0] a);
    n_checks++;
    if (a !== e) begin
      errors++;
      $display("Error at %0t ns: expected %h, got %h", $time, e, a);
    end
  endtask : chk
  task automatic cb(input logic e, input logic a);
    chk({7'h00, e}, {7'h00, a});
  endtask : cb
  // Strobes drop for one idle cycle so no signal is set twice in one step.
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_write = 1'b1;
    step(1);
    reg_write = 1'b0;
    step(1);
  endtask : wr
  task automatic rd(input logic [2:0] a, input logic [7:0] e, input logic [7:0] m);
    expq.push_back({m, e});
    reg_addr = a;
    reg_read = 1'b1;
    step(1);
    reg_read = 1'b0;
    step(1);
  endtask : rd
  task automatic fifo(input logic [3:0] s, input int n);
    if (n > 0) begin
      fs = s;
      step(n);
      fs = 4'h0;
      step(1);
    end
  endtask : fifo
  function automatic logic [31:0] nxt(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : nxt
  task automatic final_report();
    $display("Checks: %0d, errors: %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : final_report
  // ----------------------------------------------------------------
  // Read monitor and watchdog
  // ----------------------------------------------------------------
  always @(posedge clk_sys) begin
    rd_seen <= reg_read;
  end
  always @(negedge clk_sys) begin
    if (rd_seen === 1'b1 && expq.size() > 0) begin
      ent = expq.pop_front();
      chk(ent[7:0] & ent[15:8], reg_rdata & ent[15:8]);
    end
  end
  initial begin
    step(20000);
    errors++;
    final_report();
  end
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    step(20);
    reset_n = 1'b1;
    step(4);
    rd(ADDR_ENABLES, 8'h00, 8'hFF);
    rd(3'h3, 8'h00, 8'hFF);
    repeat (4) begin
      seed = nxt(seed);
      wr(ADDR_ENABLES, seed[7:0]);
      rd(ADDR_ENABLES, seed[7:0], 8'hFF);
      cb(seed[4], dp_ctrl.sleep_allowed);
    end
    wr(ADDR_ENABLES, 8'h00);
    wr(ADDR_QCR, 8'hCA);
    cb(1'b0, dp_ctrl.fifo_enable);
    cb(1'b0, polled_mode);
    wr(ADDR_QCR, 8'h01);
    cb(1'b1, polled_mode);
    for (int c = 0; c < 4; c++) begin
      wr(ADDR_QCR, {c[1:0], 6'h03});
      wr(ADDR_ENABLES, 8'h01);
      cb(1'b0, polled_mode);
      fifo(4'h1, int'(lv[c]) - 1);
      cb(1'b0, irq);
      fifo(4'h1, 1);
      cb(1'b1, irq);
      rd(ADDR_ICR, {4'h0, 4'h4}, 8'h0F);
      seed = nxt(seed);
      errs = seed[3:0];
      fde = seed[4];
      rd(ADDR_LCR, {fde, 2'h3, errs, 1'b1}, 8'hFF);
      fifo(4'h2, 1);
      cb(1'b0, irq);
      rd(ADDR_LCR, {fde, 2'h3, errs, lv[c] != 5'h01}, 8'hFF);
    end
    wr(ADDR_QCR, 8'h8B);
    fifo(4'h1, 7);
    cb(1'b1, rx_n);
    fifo(4'h1, 1);
    cb(1'b0, rx_n);
    cb(1'b1, irq);
    fifo(4'h1, 9);
    fifo(4'h2, 15);
    cb(1'b0, rx_n);
    fifo(4'h2, 1);
    cb(1'b1, rx_n);
    fifo(4'h4, 15);
    cb(1'b0, tx_n);
    wr(ADDR_ENABLES, 8'h02);
    cb(1'b1, irq);
    fifo(4'h4, 1);
    cb(1'b1, tx_n);
    cb(1'b0, irq);
    wr(ADDR_QCR, 8'h05);
    step(1);
    cb(1'b0, tx_n);
    fifo(4'h5, 1);
    cb(1'b1, tx_n);
    cb(1'b0, rx_n);
    wr(ADDR_ENABLES, 8'h02);
    cb(1'b0, irq);
    fifo(4'hA, 1);
    cb(1'b1, irq);
    rd(ADDR_LCR, {fde, 2'h3, errs, 1'b0}, 8'hFF);
    rd(ADDR_ICR, {4'hC, CAUSE_TX}, 8'hFF);
    for (int i = 0; i < 5; i++) begin
      wr(ADDR_ENABLES, eb[i]);
      cb(1'b0, irq);
      ev = ec[i];
      fs = {3'h0, i == 4};
      step(1);
      ev[2] = 1'b0;
      fs = 4'h0;
      step(2);
      cb(1'b1, irq);
      wr(ADDR_ENABLES, 8'h00);
      cb(1'b0, irq);
      ev = 5'h00;
      rd(ADDR_ICR, {4'hC, CAUSE_NONE}, 8'hFF);
      rd(ADDR_LCR, {fde, 2'h3, errs, i == 4}, 8'hFF);
    end
    final_report();
  end
endmodule : testbench
`default_nettype wire
